// File: rtl/omse_pkg.sv
// Package for the OR / move / store instruction executor.
// Assumes a 14-bit instruction word and an 8-bit data path.
package omse_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    // Opcode fields
    localparam logic [5:0] OPC_OR_ACCUM = 6'h04;
    localparam logic [5:0] OPC_COPY_FILE = 6'h08;
    localparam logic [6:0] OPC_STORE_ACCUM = 7'h01;
    localparam logic [13:0] OPC_LOAD_CONFIG = 14'h0062;
    localparam int DEST_BIT = 7;
    // File address at which the configuration register also appears
    localparam logic [6:0] CONFIG_ADDR = 7'h01;
    // Reset values
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'hff;
    localparam logic ZERO_RST = 1'b0;
endpackage : omse_pkg

// File: rtl/omse_or_move_store_insn_exec.sv
// Executes four one-cycle instructions against an external file register.
// Assumes fileRdData is the combinational read of fileAddr, same clock.
//////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1 - Opcode 000100: OR accumulator with file register, send to dest.
// RULE2 - OR dest bit 0 writes accumulator, 1 writes file register.
// RULE3 - Opcode 001000: copy file register to chosen destination.
// RULE4 - Copy dest bit 0 writes accumulator, 1 writes same register.
// RULE5 - Copy updates zero flag even when writing back to itself.
// RULE6 - Store opcode writes accumulator to file register, flags unchanged.
// RULE7 - Fixed config-load opcode copies accumulator to config, no flags.
// RULE8 - Config register also reachable as an ordinary file register.
// RULE9 - Software should prefer file stores over the config-load opcode.
// RULE10 - OR and copy set zero flag on zero result; one cycle each.
module omse_or_move_store_insn_exec (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Instruction issue
    input wire logic insnValid,
    input wire logic [omse_pkg::INSN_W-1:0] insnWord,
    // File register port
    output logic [omse_pkg::ADDR_W-1:0] fileAddr,
    input wire logic [omse_pkg::DATA_W-1:0] fileRdData,
    output logic fileWrEn_r,
    output logic [omse_pkg::DATA_W-1:0] fileWrData_r,
    output logic [omse_pkg::ADDR_W-1:0] fileWrAddr_r,
    // Architectural state
    output logic [omse_pkg::DATA_W-1:0] accum_r,
    output logic [omse_pkg::DATA_W-1:0] config_r,
    output logic zeroFlag_r
);
    import omse_pkg::*;

    typedef enum {
        OP_NONE, OP_OR, OP_COPY, OP_STORE, OP_CFG_LOAD
    } omse_op_e;

    // The decode hard-wires the opcode field positions of a 14-bit word
    if (INSN_W != 14 || DATA_W != 8 || ADDR_W != 7) begin : g_widthCheck
        $error("Executor needs 14-bit words, 8-bit data, 7-bit addresses");
    end

    // One decoder serves both the datapath and the checks below
    function automatic omse_op_e decode_op(input logic valid,
                                           input logic [INSN_W-1:0] w);
        omse_op_e op;
        op = OP_NONE;
        if (!valid) begin
            op = OP_NONE;
        end else if (w[13:8] == OPC_OR_ACCUM) begin
            op = OP_OR; // RULE1
        end else if (w[13:8] == OPC_COPY_FILE) begin
            op = OP_COPY; // RULE3
        end else if (w[13:7] == OPC_STORE_ACCUM) begin
            op = OP_STORE; // RULE6
        end else if (w == OPC_LOAD_CONFIG) begin
            op = OP_CFG_LOAD; // RULE7
        end
        // Unmatched words fall through as no operation
        return op;
    endfunction : decode_op

    omse_op_e opKind;
    logic isOr, isCopy, isStore, isCfgLoad, destFile, cfgHit;
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] accum_nxt, config_nxt, fileWrData_nxt;
    logic [ADDR_W-1:0] fileWrAddr_nxt;
    logic fileWrEn_nxt, zeroFlag_nxt;

    // Read address is the instruction field itself, so the file can
    // answer in the same cycle; this is the one combinational output.
    assign fileAddr = insnWord[ADDR_W-1:0];

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        opKind = decode_op(insnValid, insnWord);
        isOr = opKind == OP_OR; // RULE1
        isCopy = opKind == OP_COPY; // RULE3
        isStore = opKind == OP_STORE; // RULE6
        isCfgLoad = opKind == OP_CFG_LOAD; // RULE7
        destFile = insnWord[DEST_BIT];
        // Config register shadows its file address for reads
        cfgHit = fileAddr == CONFIG_ADDR; // RULE8
        result = isOr ? (accum_r | (cfgHit ? config_r : fileRdData))
                      : (cfgHit ? config_r : fileRdData); // RULE1
        accum_nxt = accum_r;
        config_nxt = config_r;
        zeroFlag_nxt = zeroFlag_r;
        fileWrEn_nxt = 1'b0;
        fileWrData_nxt = fileWrData_r;
        fileWrAddr_nxt = fileWrAddr_r;
        if (isOr || isCopy) begin
            zeroFlag_nxt = result == '0; // RULE5 RULE10
            if (destFile) begin // RULE2 RULE4
                fileWrEn_nxt = 1'b1;
                fileWrData_nxt = result;
                fileWrAddr_nxt = fileAddr;
                if (cfgHit)
                    config_nxt = result; // RULE8
            end else begin
                accum_nxt = result;
            end
        end else if (isStore) begin
            fileWrEn_nxt = 1'b1; // RULE6
            fileWrData_nxt = accum_r;
            fileWrAddr_nxt = fileAddr;
            if (cfgHit)
                config_nxt = accum_r; // RULE8
        end else if (isCfgLoad) begin
            config_nxt = accum_r; // RULE7
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            accum_r <= ACCUM_RST;
            config_r <= CONFIG_RST;
            zeroFlag_r <= ZERO_RST;
            fileWrEn_r <= 1'b0;
            fileWrData_r <= '0;
            fileWrAddr_r <= '0;
        end else begin
            accum_r <= accum_nxt;
            config_r <= config_nxt;
            zeroFlag_r <= zeroFlag_nxt;
            fileWrEn_r <= fileWrEn_nxt;
            fileWrData_r <= fileWrData_nxt;
            fileWrAddr_r <= fileWrAddr_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_orIssue;
        isOr && !cfgHit;
    endsequence
    sequence s_copyIssue;
        isCopy && !cfgHit;
    endsequence
    // Copy from the shadowed address must see config, not the file
    sequence s_cfgRead;
        isCopy && cfgHit;
    endsequence

    a_or_result: assert property (@(posedge core_clk) disable iff (rst) // RULE1
        (s_orIssue and !destFile) |=> accum_r == ($past(accum_r) |
            $past(fileRdData)))
        else $error("OR result wrong");
    a_or_file_data: assert property (@(posedge core_clk) disable iff (rst) // RULE2
        (s_orIssue and destFile) |=> fileWrData_r == ($past(accum_r) |
            $past(fileRdData)))
        else $error("OR write data wrong");
    a_copy_keep_acc: assert property (@(posedge core_clk) disable iff (rst) // RULE4
        (s_copyIssue and destFile) |=> $stable(accum_r) &&
            fileWrData_r == $past(fileRdData))
        else $error("Copy write-back data wrong");
    a_cfg_read: assert property (@(posedge core_clk) disable iff (rst) // RULE8
        (s_cfgRead and !destFile) |=> accum_r == $past(config_r))
        else $error("Config read wrong");
    a_store_keep_acc: assert property (@(posedge core_clk) disable iff (rst) // RULE6
        isStore |=> $stable(accum_r))
        else $error("Store changed accumulator");
    // Idle or unknown words must leave every piece of state alone
    a_idle_quiet: assert property (@(posedge core_clk) disable iff (rst) // RULE10
        decode_op(insnValid, insnWord) == OP_NONE |=> !fileWrEn_r &&
            $stable(accum_r) && $stable(config_r) && $stable(zeroFlag_r))
        else $error("Idle cycle changed state");
    a_or_dest_file: assert property (@(posedge core_clk) disable iff (rst) // RULE2
        isOr && destFile |=> fileWrEn_r && $stable(accum_r))
        else $error("OR file dest wrong");
    a_copy_acc: assert property (@(posedge core_clk) disable iff (rst) // RULE3
        isCopy && !destFile && !cfgHit |=> accum_r == $past(fileRdData))
        else $error("Copy to accumulator wrong");
    a_copy_file: assert property (@(posedge core_clk) disable iff (rst) // RULE4
        isCopy && destFile |=> fileWrEn_r &&
            fileWrAddr_r == $past(fileAddr))
        else $error("Copy write-back address wrong");
    a_copy_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE5
        isCopy && destFile && !cfgHit |=>
            zeroFlag_r == ($past(fileRdData) == 8'h00))
        else $error("Copy zero flag wrong");
    a_store_noflag: assert property (@(posedge core_clk) disable iff (rst) // RULE6
        isStore |=> $stable(zeroFlag_r) && fileWrEn_r &&
            fileWrData_r == $past(accum_r))
        else $error("Store wrong");
    a_cfg_load: assert property (@(posedge core_clk) disable iff (rst) // RULE7
        isCfgLoad |=> config_r == $past(accum_r) && $stable(zeroFlag_r)
            && !fileWrEn_r)
        else $error("Config load wrong");
    a_cfg_store: assert property (@(posedge core_clk) disable iff (rst) // RULE8
        isStore && cfgHit |=> config_r == $past(accum_r))
        else $error("Config store wrong");
    a_or_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE10
        isOr |=> zeroFlag_r == (($past(accum_r) |
            $past(result)) == 8'h00))
        else $error("OR zero flag wrong");
endmodule : omse_or_move_store_insn_exec

// File: testbench/tb_or_move_store_insn_exec.sv
// Self-checking bench for the OR / move / store instruction executor.
// Assumes the file read port is driven here; address 0x01 reads config_r.
module tb_or_move_store_insn_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import omse_pkg::*;
    logic core_clk, rst = 1'b1, insnValid = 1'b0, fileWrEn_r, zeroFlag_r;
    logic [13:0] insnWord = 14'h0000, w;
    logic [7:0] fileRdData = 8'h00, fileWrData_r, accum_r, config_r, rd;
    logic [6:0] fileAddr, fileWrAddr_r, eAddr = 7'h00, a;
    logic [7:0] acc = ACCUM_RST, cfg = CONFIG_RST, eData = 8'h00;
    logic z = ZERO_RST, eWen = 1'b0;
    int n_mismatch = 0, compares = 0;
    omse_or_move_store_insn_exec omse_or_move_store_insn_exec_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic [6:0] ad, input logic [7:0] d);
        eWen = 1'b1;
        eAddr = ad;
        eData = d;
        if (ad == CONFIG_ADDR) cfg = d;
    endtask : put
    // Model runs before the edge, so expectations never lean on outputs
    task automatic step(input logic v, input logic [13:0] iw,
                        input logic [7:0] r);
        logic [7:0] src, res;
        insnValid = v;
        insnWord = iw;
        fileRdData = r;
        eWen = 1'b0;
        src = (iw[6:0] == CONFIG_ADDR) ? cfg : r;
        if (v && (iw[13:8] == OPC_OR_ACCUM || iw[13:8] == OPC_COPY_FILE)) begin
            res = (iw[13:8] == OPC_OR_ACCUM) ? (acc | src) : src;
            z = (res == 8'h00);
            if (iw[DEST_BIT]) put(iw[6:0], res); else acc = res;
        end else if (v && iw[13:7] == OPC_STORE_ACCUM) begin
            put(iw[6:0], acc);
        end else if (v && iw == OPC_LOAD_CONFIG) begin
            cfg = acc;
        end
        @(posedge core_clk);
        #2;
        chk(8'(fileAddr), 8'(iw[6:0]));
        chk(accum_r, acc);
        chk(config_r, cfg);
        chk(8'(zeroFlag_r), 8'(z));
        chk(8'(fileWrEn_r), 8'(eWen));
        chk(fileWrData_r, eData);
        chk(8'(fileWrAddr_r), 8'(eAddr));
    endtask : step
    task automatic wrap_up;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    //////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(79));
        repeat (8) @(posedge core_clk);
        #2;
        rst = 1'b0;
        // Zero results, self copy, config through both paths, idle slot
        step(1'b1, {OPC_OR_ACCUM, 1'b0, 7'h10}, 8'h00);
        step(1'b1, {OPC_COPY_FILE, 1'b1, 7'h20}, 8'h00);
        step(1'b1, OPC_LOAD_CONFIG, 8'h33);
        step(1'b1, {OPC_COPY_FILE, 1'b0, CONFIG_ADDR}, 8'h5a);
        step(1'b0, {OPC_STORE_ACCUM, 7'h05}, 8'h00);
        step(1'b1, {OPC_STORE_ACCUM, CONFIG_ADDR}, 8'h00);
        for (int i = 0; i < 300; i++) begin
            a = ($urandom_range(3) == 0) ? CONFIG_ADDR : 7'($urandom);
            rd = ($urandom_range(3) == 0) ? 8'h00 : 8'($urandom);
            case ($urandom_range(4))
                0: w = {OPC_OR_ACCUM, 1'($urandom), a};
                1: w = {OPC_COPY_FILE, 1'($urandom), a};
                2: w = {OPC_STORE_ACCUM, a};
                3: w = OPC_LOAD_CONFIG;
                default: w = 14'($urandom);
            endcase
            step($urandom_range(7) != 0, w, rd);
        end
        insnValid = 1'b0;
        wrap_up;
    end
    // About 320 cycles expected; cut off well beyond that
    initial begin
        #20000;
        n_mismatch++;
        wrap_up;
    end
endmodule : tb_or_move_store_insn_exec
